//--- design/sdis_int_status.sv
// Interrupt status register block of an SD card host controller
// Notes on behaviour
// R1: Event flags are sticky; write 1 clears, write 0 keeps.
// R2: Bus error response on the data master sets the bus response flag.
// R3: Auto stop detail bit rising, or skipped auto stop, sets its flag.
// R4: Power limit flag is live: one while card power is cut.
// R5: Zero end bit of read data or CRC token sets data end flag.
// R6: Read CRC failure or write status not 010 sets data CRC flag.
// R7: Data wait expiry or busy timeout sets data timeout flag.
// R8: Response index mismatch sets command index flag.
// R9: Response end bit zero sets command end-bit flag.
// R10: Response CRC failure without timeout sets command CRC flag.
// R11: CMD conflict aborts drive and sets command CRC and timeout.
// R12: No response start within 64 card clocks sets command timeout.
// R13: Card interrupt flag ignores write 1; follows card source.
// R14: 1-bit mode sees card interrupt unclocked; 4-bit only in window.
// R15: Clearing card interrupt enable drops latched card state.
// R16: Buffer read/write enable rising sets read/write ready flags.
// R17: DMA boundary reached sets DMA flag.
// R18: Stop-at-gap pending: active state falling sets block pause flag.
// R19: Transfer done on read-active fall (read) or line-active fall (write).
// R20: Response end bit sets command complete, except auto stop.
// R21: Software reads done plus timeout as done; timeout plus complete as bad.
// R22: Data soft reset clears ready, pause and done flags.
// R23: Command soft reset clears command complete.
// R24: Data wait is timeout clock times 2^(13+n); 1111 reserved.
// R25: Interrupt output high while any flag and its signal enable set.
//
// Local design decision: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module sdis_int_status
   import sdis_pkg::*;
#(
   parameter int RESP_WAIT = SDIS_RESP_WAIT_CYC
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic card_bus_clock_i,
   input wire logic cmd_line_i,
   input wire logic card_int_line_i,
   input wire logic timeout_base_tick_i,
   input wire sdis_pkg::sdis_evt_s evt_i,
   input wire sdis_pkg::sdis_lvl_s lvl_i,
   output logic cmd_abort_o,
   output logic data_path_soft_reset_o,
   output logic command_path_soft_reset_o,
   output logic irq_o
);
   import sdis_pkg::*;

   typedef struct packed {
      logic [31:0] flags;
      logic [31:0] sig_en;
      logic [31:0] ctrl;
      logic [31:0] rdata;
      logic ack;
      logic [2:0] clk_sync;
      logic [2:0] cmd_sync;
      logic [2:0] int_sync;
      logic clk_prev;
      logic cmd_stable;
      logic int_stable;
      logic int_latch;
      logic [7:0] resp_cnt;
      logic resp_wait;
      logic check_cmd;
      logic [27:0] dat_cnt;
      sdis_lvl_s lvl_prev;
      logic abort;
      logic irq;
   } sdis_state_s;

   sdis_state_s s_q;
   sdis_state_s s_d;

   // Mask byte lanes of a write
   function automatic logic [31:0] sdis_lanes(input logic [3:0] sel);
      sdis_lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // Card clock rising edge, from the agreeing synchroniser stages
   logic sd_rise;
   logic wb_req;
   logic [31:0] wmask;
   logic [31:0] set_v;
   logic [31:0] clr_v;
   logic [27:0] dat_limit;
   logic [4:0] exp_v;
   logic cmd_src;

   // Next state
   always_comb
   begin
      s_d = s_q;
      set_v = 32'h0000_0000;
      clr_v = 32'h0000_0000;
      wb_req = wb_cyc_i && wb_stb_i && !s_q.ack;
      wmask = sdis_lanes(wb_sel_i) & wb_dat_i;
      cmd_src = 1'b0;
      // Synchronisers: stage 0 feeds stage 1 only
      s_d.clk_sync = {s_q.clk_sync[1:0], card_bus_clock_i};
      s_d.cmd_sync = {s_q.cmd_sync[1:0], cmd_line_i};
      s_d.int_sync = {s_q.int_sync[1:0], ~card_int_line_i};
      if (s_q.clk_sync[1] == s_q.clk_sync[2])
      begin
         s_d.clk_prev = s_q.clk_sync[2];
      end
      if (s_q.cmd_sync[1] == s_q.cmd_sync[2])
      begin
         s_d.cmd_stable = s_q.cmd_sync[2];
      end
      if (s_q.int_sync[1] == s_q.int_sync[2])
      begin
         s_d.int_stable = s_q.int_sync[2];
      end
      sd_rise = (s_q.clk_sync[1] == s_q.clk_sync[2]) && s_q.clk_sync[2] && !s_q.clk_prev;
      // Command line conflict: high driven, low seen at next card clock edge
      s_d.abort = 1'b0;
      if (evt_i.cmd_drive_high)
      begin
         s_d.check_cmd = 1'b1;
      end
      if (s_q.check_cmd && sd_rise)
      begin
         s_d.check_cmd = 1'b0;
         if (!s_q.cmd_stable)
         begin
            s_d.abort = 1'b1; // R11
            set_v[SDIS_B_CMD_CRC] = 1'b1; // R11
            set_v[SDIS_B_CMD_TMO] = 1'b1; // R11
            s_d.resp_wait = 1'b0;
         end
      end
      // Response wait counter in card clocks
      if (evt_i.cmd_sent_end)
      begin
         s_d.resp_wait = 1'b1;
         s_d.resp_cnt = 8'h00;
      end
      else if (s_q.resp_wait && !s_q.cmd_stable)
      begin
         s_d.resp_wait = 1'b0; // Start bit seen
      end
      else if (s_q.resp_wait && sd_rise)
      begin
         s_d.resp_cnt = s_q.resp_cnt + 8'h01;
         if (s_q.resp_cnt == 8'(RESP_WAIT - 1))
         begin
            set_v[SDIS_B_CMD_TMO] = 1'b1; // R12
            s_d.resp_wait = 1'b0;
         end
      end
      // Data wait: timeout base ticks against 2^(13+n)
      exp_v = 5'(s_q.ctrl[SDIS_B_WAIT_EXP +: 4]) + 5'(SDIS_WAIT_EXP_OFS); // R24
      dat_limit = 28'h000_0001 << exp_v;
      if (!lvl_i.data_wait)
      begin
         s_d.dat_cnt = 28'h000_0000;
      end
      else if (timeout_base_tick_i && s_q.ctrl[SDIS_B_WAIT_EXP +: 4] <= SDIS_WAIT_EXP_MAX)
      begin
         s_d.dat_cnt = s_q.dat_cnt + 28'h000_0001;
         if (s_q.dat_cnt == dat_limit - 28'h000_0001)
         begin
            set_v[SDIS_B_DAT_TMO] = 1'b1; // R7
         end
      end
      // Command response events
      if (evt_i.resp_end)
      begin
         if (!evt_i.resp_auto_stop)
         begin
            set_v[SDIS_B_CMD_DONE] = 1'b1; // R20
            set_v[SDIS_B_CMD_IDX] = evt_i.resp_idx_bad; // R8
            set_v[SDIS_B_CMD_END] = evt_i.resp_end_bit_bad; // R9
            set_v[SDIS_B_CMD_CRC] = set_v[SDIS_B_CMD_CRC] | (evt_i.resp_crc_bad && !s_q.flags[SDIS_B_CMD_TMO]); // R10
         end
      end
      // Data path errors
      set_v[SDIS_B_DAT_END] = evt_i.rd_end_bit_bad || (evt_i.wr_status_valid && evt_i.wr_status_end_bad); // R5
      set_v[SDIS_B_DAT_CRC] = evt_i.rd_crc_bad || (evt_i.wr_status_valid && evt_i.wr_crc_status != 3'b010); // R6
      set_v[SDIS_B_DAT_TMO] = set_v[SDIS_B_DAT_TMO] | evt_i.busy_tmo; // R7
      set_v[SDIS_B_BUS_RESP] = evt_i.bus_err_resp; // R2
      set_v[SDIS_B_DMA] = evt_i.dma_boundary; // R17
      set_v[SDIS_B_AUTO_STOP] = evt_i.auto_stop_skipped ||
         |(lvl_i.auto_stop_detail & ~s_q.lvl_prev.auto_stop_detail); // R3
      // Level edges from the data path
      set_v[SDIS_B_RD_RDY] = lvl_i.buf_rd_en && !s_q.lvl_prev.buf_rd_en; // R16
      set_v[SDIS_B_WR_RDY] = lvl_i.buf_wr_en && !s_q.lvl_prev.buf_wr_en; // R16
      if (lvl_i.stop_gap_req)
      begin
         set_v[SDIS_B_BLK_PAUSE] = lvl_i.is_write ? (!lvl_i.wr_active && s_q.lvl_prev.wr_active)
            : (!lvl_i.dat_active && s_q.lvl_prev.dat_active); // R18
      end
      set_v[SDIS_B_XFER_DONE] = lvl_i.is_write ? (!lvl_i.dat_active && s_q.lvl_prev.dat_active)
         : (!lvl_i.rd_active && s_q.lvl_prev.rd_active); // R19
      s_d.lvl_prev = lvl_i;
      // Card interrupt source, sampled per bus width
      if (s_q.ctrl[SDIS_B_WIDE_BUS])
      begin
         cmd_src = s_q.int_stable && !lvl_i.dat_active; // R14
      end
      else
      begin
         cmd_src = s_q.int_stable; // R14
      end
      s_d.int_latch = s_q.sig_en[SDIS_B_CARD_INT] && cmd_src; // R15 R13
      // Bus access: ack one cycle after the request is seen
      s_d.ack = wb_req;
      if (wb_req && wb_we_i)
      begin
         unique case (wb_adr_i)
            SDIS_OFS_FLAGS: clr_v = wmask & SDIS_W1C_MASK; // R1
            SDIS_OFS_SIG_EN: s_d.sig_en = ((s_q.sig_en & ~sdis_lanes(wb_sel_i))
               | (wb_dat_i & sdis_lanes(wb_sel_i))) & SDIS_SIG_EN_MASK;
            SDIS_OFS_CTRL: s_d.ctrl = (s_q.ctrl & ~sdis_lanes(wb_sel_i)) | (wb_dat_i & sdis_lanes(wb_sel_i));
            default: ;
         endcase
      end
      s_d.rdata = 32'h0000_0000;
      if (wb_req && !wb_we_i)
      begin
         unique case (wb_adr_i)
            SDIS_OFS_FLAGS: s_d.rdata = s_q.flags;
            SDIS_OFS_SIG_EN: s_d.rdata = s_q.sig_en;
            SDIS_OFS_CTRL: s_d.rdata = s_q.ctrl;
            SDIS_OFS_AUTO_STOP: s_d.rdata = {27'h000_0000, lvl_i.auto_stop_detail};
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
      // Soft resets: hold one cycle, then self-clear
      if (s_q.ctrl[SDIS_B_RST_DAT])
      begin
         s_d.ctrl[SDIS_B_RST_DAT] = 1'b0;
         clr_v = clr_v | SDIS_DAT_RST_MASK; // R22
         s_d.dat_cnt = 28'h000_0000;
      end
      if (s_q.ctrl[SDIS_B_RST_CMD])
      begin
         s_d.ctrl[SDIS_B_RST_CMD] = 1'b0;
         clr_v[SDIS_B_CMD_DONE] = 1'b1; // R23
         s_d.resp_wait = 1'b0;
         s_d.check_cmd = 1'b0;
      end
      // Sticky flags: set wins over clear
      s_d.flags = ((s_q.flags & ~clr_v) | set_v) & SDIS_W1C_MASK; // R1
      s_d.flags[SDIS_B_PWR_LIM] = lvl_i.pwr_fail; // R4
      s_d.flags[SDIS_B_CARD_INT] = s_q.int_latch; // R13
      // Summary follows the new error bits in the same cycle, never a stale word
      s_d.flags[SDIS_B_ERR_SUM] = |(s_d.flags[31:16]);
      s_d.irq = |(s_q.flags & s_q.sig_en); // R25
   end

   // State register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops
   assign wb_dat_o = s_q.rdata;
   assign wb_ack_o = s_q.ack;
   assign cmd_abort_o = s_q.abort;
   assign data_path_soft_reset_o = s_q.ctrl[SDIS_B_RST_DAT];
   assign command_path_soft_reset_o = s_q.ctrl[SDIS_B_RST_CMD];
   assign irq_o = s_q.irq;
endmodule
`default_nettype wire

//--- design/sdis_pkg.sv
// Package for the SD host interrupt status block: offsets, bit positions, timing, carriers
package sdis_pkg;
   // Register byte offsets
   localparam logic [7:0] SDIS_OFS_FLAGS = 8'h30;
   localparam logic [7:0] SDIS_OFS_SIG_EN = 8'h38;
   localparam logic [7:0] SDIS_OFS_CTRL = 8'h2C;
   localparam logic [7:0] SDIS_OFS_AUTO_STOP = 8'h3C;
   localparam logic [31:0] SDIS_FLAGS_RESET = 32'h0000_0000;
   // Flag bit positions
   localparam int SDIS_B_CMD_DONE = 0;
   localparam int SDIS_B_XFER_DONE = 1;
   localparam int SDIS_B_BLK_PAUSE = 2;
   localparam int SDIS_B_DMA = 3;
   localparam int SDIS_B_WR_RDY = 4;
   localparam int SDIS_B_RD_RDY = 5;
   localparam int SDIS_B_CARD_INT = 8;
   localparam int SDIS_B_ERR_SUM = 15;
   localparam int SDIS_B_CMD_TMO = 16;
   localparam int SDIS_B_CMD_CRC = 17;
   localparam int SDIS_B_CMD_END = 18;
   localparam int SDIS_B_CMD_IDX = 19;
   localparam int SDIS_B_DAT_TMO = 20;
   localparam int SDIS_B_DAT_CRC = 21;
   localparam int SDIS_B_DAT_END = 22;
   localparam int SDIS_B_PWR_LIM = 23;
   localparam int SDIS_B_AUTO_STOP = 24;
   localparam int SDIS_B_BUS_RESP = 28;
   // Control register fields
   localparam int SDIS_B_RST_CMD = 25;
   localparam int SDIS_B_RST_DAT = 26;
   localparam int SDIS_B_WAIT_EXP = 16;
   localparam int SDIS_B_WIDE_BUS = 1;
   // Write-one-to-clear flags (card interrupt and power limit are live)
   localparam logic [31:0] SDIS_W1C_MASK = 32'hF17F_003F;
   localparam logic [31:0] SDIS_SIG_EN_MASK = 32'hF1FF_013F;
   localparam logic [31:0] SDIS_DAT_RST_MASK = 32'h0000_0036;
   // Response wait on the command line, card clock cycles
   localparam int SDIS_RESP_WAIT_CYC = 64;
   localparam logic [3:0] SDIS_WAIT_EXP_BASE = 4'h0;
   localparam int SDIS_WAIT_EXP_OFS = 13;
   localparam logic [3:0] SDIS_WAIT_EXP_MAX = 4'hE;
   // Synchronised events from the command, data and system paths
   typedef struct packed {
      logic resp_end;
      logic resp_auto_stop;
      logic resp_crc_bad;
      logic resp_idx_bad;
      logic resp_end_bit_bad;
      logic cmd_sent_end;
      logic cmd_drive_high;
      logic rd_crc_bad;
      logic rd_end_bit_bad;
      logic [2:0] wr_crc_status;
      logic wr_status_valid;
      logic wr_status_end_bad;
      logic busy_tmo;
      logic auto_stop_skipped;
      logic dma_boundary;
      logic bus_err_resp;
   } sdis_evt_s;
   // Present state levels from the data path
   typedef struct packed {
      logic buf_rd_en;
      logic buf_wr_en;
      logic rd_active;
      logic wr_active;
      logic dat_active;
      logic stop_gap_req;
      logic is_write;
      logic data_wait;
      logic pwr_fail;
      logic [4:0] auto_stop_detail;
   } sdis_lvl_s;
endpackage

//--- testbench/sdis_card_model.sv
// Card side model: command response, line clash and card interrupt
`timescale 1ns/10ps
`default_nettype none
module sdis_card_model
(
   input wire logic card_clk_i,
   input wire logic resp_i,
   input wire logic clash_i,
   input wire logic irq_i,
   output logic cmd_o,
   output logic int_n_o
);
   logic [1:0] cnt_q;
   // Response start bit comes after two card clocks, well inside a short wait
   always_ff @(posedge card_clk_i)
   begin
      if (!resp_i)
         cnt_q <= 2'h0;
      else if (cnt_q != 2'h3)
         cnt_q <= cnt_q + 2'h1;
   end
   // Pulled-up lines: released means high
   assign cmd_o = !(clash_i || (resp_i && cnt_q >= 2'h2));
   assign int_n_o = !irq_i;
endmodule
`default_nettype wire

//--- testbench/sdis_int_status_checker.sv
// Port checker of the interrupt status block
`timescale 1ns/10ps
`default_nettype none
module sdis_int_status_checker
#(
   parameter int RESP_WAIT = sdis_pkg::SDIS_RESP_WAIT_CYC
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire sdis_pkg::sdis_evt_s evt_i,
   input wire sdis_pkg::sdis_lvl_s lvl_i,
   input wire logic cmd_abort_o,
   input wire logic data_path_soft_reset_o,
   input wire logic command_path_soft_reset_o
);
   import sdis_pkg::*;
   logic [5:0] armed_q;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Cycles since the last drive-high check was armed
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         armed_q <= 6'h3F;
      else if (evt_i.cmd_drive_high)
         armed_q <= 6'h00;
      else if (armed_q != 6'h3F)
         armed_q <= armed_q + 6'h01;
   end
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack1: assert property (p_ack1) else $error("ack too long");
   property p_dat0; !wb_ack_o |-> wb_dat_o == '0; endproperty
   a_dat0: assert property (p_dat0) else $error("read data outside ack");
   property p_fmt; wb_ack_o && !wb_we_i && wb_adr_i == SDIS_OFS_FLAGS
      |-> wb_dat_o[15] == |wb_dat_o[31:16] && (wb_dat_o & 32'hEE00_7EC0) == '0; endproperty
   a_fmt: assert property (p_fmt) else $error("flag word malformed");
   property p_pwr; $stable(lvl_i.pwr_fail)[*3] ##0 (wb_ack_o && !wb_we_i && wb_adr_i == SDIS_OFS_FLAGS)
      |-> wb_dat_o[SDIS_B_PWR_LIM] == lvl_i.pwr_fail; endproperty
   a_pwr: assert property (p_pwr) else $error("power flag not live");
   property p_abort; cmd_abort_o |-> armed_q < 6'h18 ##1 !cmd_abort_o; endproperty
   a_abort: assert property (p_abort) else $error("abort without conflict check");
   property p_crst; wb_ack_o && wb_we_i && wb_adr_i == SDIS_OFS_CTRL && wb_sel_i[3] && wb_dat_i[SDIS_B_RST_CMD]
      |-> command_path_soft_reset_o ##1 !command_path_soft_reset_o; endproperty
   a_crst: assert property (p_crst) else $error("command reset missing");
   property p_drst; wb_ack_o && wb_we_i && wb_adr_i == SDIS_OFS_CTRL && wb_sel_i[3] && wb_dat_i[SDIS_B_RST_DAT]
      |-> data_path_soft_reset_o ##1 !data_path_soft_reset_o; endproperty
   a_drst: assert property (p_drst) else $error("data reset missing");
endmodule
bind sdis_int_status sdis_int_status_checker #(.RESP_WAIT(RESP_WAIT)) chk_u (.clk_i, .rst_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .evt_i, .lvl_i,
   .cmd_abort_o, .data_path_soft_reset_o, .command_path_soft_reset_o);
`default_nettype wire

//--- testbench/test_sdis_int_status.sv
// Self-checking bench of the interrupt status block
`timescale 1ns/10ps
`default_nettype none
module test_sdis_int_status;
   import sdis_pkg::*;
   localparam logic [17:0] EV [14] = '{18'h0_0001, 18'h0_0004, 18'h0_0200, 18'h0_0400, 18'h0_0008, 18'h2_4000,
      18'h2_2000, 18'h2_8000, 18'h0_0002, 18'h2_0000, 18'h0_0160, 18'h0_00B0, 18'h0_00A0, 18'h3_0000};
   localparam logic [31:0] EXP [14] = '{32'h1000_8000, 32'h0100_8000, 32'h0040_8000, 32'h0020_8000,
      32'h0010_8000, 32'h0008_8001, 32'h0004_8001, 32'h0002_8001, 32'h0000_0008, 32'h0000_0001,
      32'h0020_8000, 32'h0040_8000, 32'h0000_0000, 32'h0000_0000};
   localparam logic [7:0] FL = SDIS_OFS_FLAGS;
   logic clk_i, rst_i, card_clk, cmd_line, int_n, resp, clash, irq_req, tick, cyc, stb, we, ack, abort, irq;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, rd;
   sdis_evt_s evt;
   sdis_lvl_s lvl;
   int n_errors, total_checks, seed, i, n;
   sdis_int_status #(.RESP_WAIT(4)) dut_u (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .card_bus_clock_i(card_clk), .cmd_line_i(cmd_line), .card_int_line_i(int_n), .timeout_base_tick_i(tick),
      .evt_i(evt), .lvl_i(lvl), .cmd_abort_o(abort), .data_path_soft_reset_o(), .command_path_soft_reset_o(),
      .irq_o(irq));
   sdis_card_model card_u (.card_clk_i(card_clk), .resp_i(resp), .clash_i(clash), .irq_i(irq_req),
      .cmd_o(cmd_line), .int_n_o(int_n));
   function automatic logic [31:0] fe(input int b);
      if (b < 0)
         return 32'h0000_0000;
      return (32'h0000_0001 << b) | ((b > 15) ? 32'h0000_8000 : 32'h0000_0000);
   endfunction
   task automatic stop_test;
      if (n_errors == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic bus cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      chk(n < 20, 1'b1);
      if (n >= 20)
         stop_test();
      @(posedge clk_i);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      chk(rd, e);
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   initial
   begin
      card_clk = 1'b0;
      forever #80 card_clk = ~card_clk;
   end
   // Hang guard
   initial
   begin
      #1000000;
      n_errors++;
      stop_test();
   end
   initial
   begin
      {rst_i, resp, clash, irq_req, tick, cyc, stb, we} = 8'h81;
      {adr, wdat, evt, lvl} = '0;
      {n_errors, total_checks, seed} = {32'h0, 32'h0, 32'h5ab3};
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rc(FL, SDIS_FLAGS_RESET);
      wdat = $random(seed);
      wb(1'b1, SDIS_OFS_SIG_EN, wdat);
      rc(SDIS_OFS_SIG_EN, wdat & SDIS_SIG_EN_MASK);
      rc(8'h40, 32'h0000_0000);
      wb(1'b1, SDIS_OFS_SIG_EN, 32'h0000_0100);
      // Event sources except cmd_sent_end and cmd_drive_high: set, keep on write 0, clear on write 1
      for (i = 0; i < 14; i++)
      begin
         evt <= EV[i];
         @(posedge clk_i);
         evt <= '0;
         @(posedge clk_i);
         rc(FL, EXP[i]);
         wb(1'b1, FL, $random(seed) & ~EXP[i]);
         rc(FL, EXP[i]);
         wb(1'b1, FL, EXP[i]);
         rc(FL, 32'h0000_0000);
      end
      lvl <= 14'h3B04;
      repeat (4) @(posedge clk_i);
      // Stop-at-gap request stays pending while the active states fall
      lvl <= 14'h0100;
      repeat (4) @(posedge clk_i);
      rc(FL, SDIS_DAT_RST_MASK | fe(24));
      wb(1'b1, SDIS_OFS_CTRL, 32'h0400_0000);
      wb(1'b1, SDIS_OFS_CTRL, 32'h0000_0000);
      rc(FL, fe(24));
      evt <= 18'h2_0000;
      @(posedge clk_i);
      evt <= '0;
      wb(1'b1, SDIS_OFS_CTRL, 32'h0200_0000);
      wb(1'b1, SDIS_OFS_CTRL, 32'h0000_0000);
      rc(FL, fe(24));
      wb(1'b1, FL, 32'hFFFF_FFFF);
      lvl <= 14'h0020;
      repeat (4) @(posedge clk_i);
      wb(1'b1, FL, fe(23));
      rc(FL, fe(23));
      lvl <= '0;
      repeat (4) @(posedge clk_i);
      rc(FL, 32'h0000_0000);
      // Card interrupt in 1-bit mode, then in 4-bit mode
      irq_req <= 1'b1;
      repeat (6) @(posedge clk_i);
      wb(1'b1, FL, fe(8));
      rc(FL, fe(8));
      chk(irq, 1'b1);
      wb(1'b1, SDIS_OFS_SIG_EN, 32'h0000_0000);
      rc(FL, 32'h0000_0000);
      chk(irq, 1'b0);
      wb(1'b1, SDIS_OFS_CTRL, 32'h0000_0002);
      lvl <= 14'h0200;
      wb(1'b1, SDIS_OFS_SIG_EN, 32'h0000_0100);
      repeat (6) @(posedge clk_i);
      rc(FL, 32'h0000_0000);
      lvl <= '0;
      repeat (6) @(posedge clk_i);
      rc(FL, fe(8));
      irq_req <= 1'b0;
      repeat (6) @(posedge clk_i);
      rc(FL, 32'h0000_0000);
      // Response timeout, then a prompt response
      evt <= 18'h0_1000;
      @(posedge clk_i);
      evt <= '0;
      repeat (60) @(posedge clk_i);
      rc(FL, fe(16));
      wb(1'b1, FL, fe(16));
      resp <= 1'b1;
      evt <= 18'h0_1000;
      @(posedge clk_i);
      evt <= '0;
      repeat (60) @(posedge clk_i);
      rc(FL, 32'h0000_0000);
      resp <= 1'b0;
      clash <= 1'b1;
      repeat (6) @(posedge clk_i);
      evt <= 18'h0_0800;
      @(posedge clk_i);
      evt <= '0;
      for (n = 0; abort !== 1'b1 && n < 40; n++)
         @(posedge clk_i);
      chk(n < 40, 1'b1);
      rc(FL, fe(16) | fe(17));
      wb(1'b1, FL, 32'hFFFF_FFFF);
      clash <= 1'b0;
      // Data timeout with exponent 0000: 2^13 ticks
      lvl <= 14'h0040;
      tick <= 1'b1;
      repeat (8150) @(posedge clk_i);
      rc(FL, 32'h0000_0000);
      repeat (100) @(posedge clk_i);
      rc(FL, fe(20));
      stop_test();
   end
endmodule
`default_nettype wire
